// ---- design/xor_tree_board_test_port.sv ----
`timescale 1ns/10ps

// Behaviour
// RQ1: The tester asks for floating mode by holding select 1, execute 0, clock 0, data 1 in reset.
// RQ2: In floating mode every pad is high impedance and all pull resistors are off.
// RQ3: The tester enters XOR mode with select 1, execute 1, clock 0, data 1 and isolation 1.
// RQ4: The tester holds the bus isolation input high before and during the XOR test.
// RQ5: In XOR mode every peripheral input buffer feeds an XOR tree so any toggle flips the output.
// RQ6: In XOR mode all output drivers float except the two that carry chain results.
// RQ7: Chain one drives the flash output-enable pin and chain two the flash write-enable pin.
// RQ8: Chain one covers 42 positions of bus pins and chain two 46 positions of peripheral pins; the code's chain two has 41 (CHAIN2_LEN).
// RQ9: The tester drives the covered pins, watches the outputs and straps none of them.
// RQ10: Each chain output follows its input pins combinationally with no clock edge.
// RQ11: With test select low both test modes are off and pins work normally.
module xor_tree_board_test_port #(
    parameter int CHAIN1_W = tap_pkg::CHAIN1_LEN,
    parameter int CHAIN2_W = tap_pkg::CHAIN2_LEN,
    parameter int PADS     = tap_pkg::PAD_OUTS
) (
    input  wire logic                mclk,          // 25 MHz clock
    input  wire logic                rst_n,         // Synchronous reset
    input  wire tap_pkg::test_pins_t test_pins,     // Tester pin levels
    input  wire logic [CHAIN1_W-1:0] chain1_in,     // Input buffers, chain one order
    input  wire logic [CHAIN2_W-1:0] chain2_in,     // Input buffers, chain two order
    input  wire logic                func_rd_strobe_n, // Normal flash output-enable value
    input  wire logic                func_wr_strobe_n, // Normal flash write-enable value
    input  wire logic [PADS-1:0]     func_oe_n,     // Normal pad enables
    output logic                     flash_output_enable_n,    // Chain one result pin
    output logic                     flash_output_enable_oe_n, // Its driver enable
    output logic                     flash_write_enable_n,     // Chain two result pin
    output logic                     flash_write_enable_oe_n,  // Its driver enable
    output logic [PADS-1:0]          pad_oe_n,      // Other pad driver enables
    output logic                     pulls_en,      // Internal pull resistors on
    output tap_pkg::mode_t           mode           // Current test mode
);

    // Refuse empty chains or pad groups at elaboration
    if (CHAIN1_W < 1 || CHAIN2_W < 1 || PADS < 1)
    begin : g_bad_sizes
        $error("Chains and pad count must be at least one");
    end

    // ------------------------------------------------------------
    // Mode capture
    // ------------------------------------------------------------
    tap_pkg::mode_t mode_ff;
    tap_pkg::mode_t nxt_mode;
    logic           float_req;
    logic           xor_req;

    // Shared decode of the chain result mode
    function automatic logic is_xor(input tap_pkg::mode_t m);
        return m == tap_pkg::MODE_XOR;
    endfunction

    assign float_req = test_pins.select == tap_pkg::REQ_SELECT
                    && test_pins.execute == tap_pkg::FLOAT_EXECUTE
                    && test_pins.clock == tap_pkg::REQ_CLOCK
                    && test_pins.data_in == tap_pkg::REQ_DATA_IN;  // RQ1
    assign xor_req = test_pins.select == tap_pkg::REQ_SELECT
                  && test_pins.execute == tap_pkg::XOR_EXECUTE
                  && test_pins.clock == tap_pkg::REQ_CLOCK
                  && test_pins.data_in == tap_pkg::REQ_DATA_IN
                  && test_pins.isolation_n;                        // RQ3 RQ4

    always_comb
    begin
        nxt_mode = mode_ff;
        if (!test_pins.select)
            nxt_mode = tap_pkg::MODE_NORMAL;                       // RQ11
        else if (mode_ff == tap_pkg::MODE_FLOAT)
            nxt_mode = tap_pkg::MODE_FLOAT;
        else if (xor_req)
            nxt_mode = tap_pkg::MODE_XOR;                          // RQ3
        else
            nxt_mode = tap_pkg::MODE_NORMAL;
    end

    // Float is only latched while reset is held; sync reset lets us sample pins
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            mode_ff <= float_req ? tap_pkg::MODE_FLOAT : tap_pkg::MODE_NORMAL;  // RQ1
        else
            mode_ff <= nxt_mode;
    end

    assign mode = mode_ff;

    // ------------------------------------------------------------
    // Pad drivers and pulls
    // ------------------------------------------------------------
    logic [PADS-1:0] pad_oe_n_ff;
    logic            pulls_ff;
    logic            rd_oe_n_ff;
    logic            wr_oe_n_ff;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            pad_oe_n_ff <= {PADS{tap_pkg::OE_N_FLOAT}};
        else if (nxt_mode != tap_pkg::MODE_NORMAL)
            pad_oe_n_ff <= {PADS{tap_pkg::OE_N_FLOAT}};            // RQ2 RQ6
        else
            pad_oe_n_ff <= func_oe_n;                              // RQ11
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            pulls_ff <= 1'b0;
        else
            pulls_ff <= nxt_mode != tap_pkg::MODE_FLOAT;           // RQ2
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            rd_oe_n_ff <= tap_pkg::OE_N_FLOAT;
            wr_oe_n_ff <= tap_pkg::OE_N_FLOAT;
        end
        else if (nxt_mode == tap_pkg::MODE_FLOAT)
        begin
            rd_oe_n_ff <= tap_pkg::OE_N_FLOAT;                     // RQ2
            wr_oe_n_ff <= tap_pkg::OE_N_FLOAT;
        end
        else
        begin
            // Result pins stay driven in XOR mode
            rd_oe_n_ff <= tap_pkg::OE_N_DRIVE;                     // RQ6
            wr_oe_n_ff <= tap_pkg::OE_N_DRIVE;
        end
    end

    assign pad_oe_n                 = pad_oe_n_ff;
    assign pulls_en                 = pulls_ff;
    assign flash_output_enable_oe_n = rd_oe_n_ff;
    assign flash_write_enable_oe_n  = wr_oe_n_ff;

    // ------------------------------------------------------------
    // XOR chains
    // ------------------------------------------------------------
    // Results bypass flops on purpose: the tree must work with no clock
    logic chain1_out;
    logic chain2_out;

    assign chain1_out = ^chain1_in;                                // RQ5 RQ8
    assign chain2_out = ^chain2_in;                                // RQ5 RQ8

    // Only these two outputs are not flopped; a tester may run with mclk stopped
    assign flash_output_enable_n = is_xor(mode_ff) ? chain1_out
                                                   : func_rd_strobe_n;  // RQ7 RQ10
    assign flash_write_enable_n  = is_xor(mode_ff) ? chain2_out
                                                   : func_wr_strobe_n;  // RQ7 RQ10

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_float_hiz_pads: assert property (  // RQ2
        mode_ff == tap_pkg::MODE_FLOAT |-> &pad_oe_n && !pulls_en
            && flash_output_enable_oe_n && flash_write_enable_oe_n)
        else $error("Floating mode left a pad driven or pull on");

    a_xor_pads_off: assert property (  // RQ6
        mode_ff == tap_pkg::MODE_XOR |-> &pad_oe_n)
        else $error("Pad driven in XOR mode");

    a_xor_results_on: assert property (  // RQ6
        mode_ff == tap_pkg::MODE_XOR |-> !flash_output_enable_oe_n
            && !flash_write_enable_oe_n)
        else $error("Chain result pin not driven");

    a_chain1_value: assert property (  // RQ7
        mode_ff == tap_pkg::MODE_XOR |-> flash_output_enable_n == ^chain1_in)
        else $error("Chain one result wrong");

    a_chain2_value: assert property (  // RQ7
        mode_ff == tap_pkg::MODE_XOR |-> flash_write_enable_n == ^chain2_in)
        else $error("Chain two result wrong");

    a_chain_follows: assert property (  // RQ5 RQ10
        mode_ff == tap_pkg::MODE_XOR && $changed(chain1_in) && $stable(mode_ff)
            && $countones(chain1_in ^ $past(chain1_in)) == 1
            |-> flash_output_enable_n != $past(flash_output_enable_n))
        else $error("Single toggle did not flip chain one");

    a_xor_entry: assert property (  // RQ3
        xor_req && mode_ff == tap_pkg::MODE_NORMAL |=> mode_ff == tap_pkg::MODE_XOR)
        else $error("XOR mode not entered");

    a_select_low: assert property (  // RQ11
        !test_pins.select |=> mode_ff == tap_pkg::MODE_NORMAL && pulls_en)
        else $error("Test mode held with select low");

    a_float_holds: assert property (  // RQ1
        mode_ff == tap_pkg::MODE_FLOAT && test_pins.select
            |=> mode_ff == tap_pkg::MODE_FLOAT)
        else $error("Floating mode dropped");

    // ------------------------------------------------------------
    // Entry, exit, normal-mode, XOR pull and chain two follow checks
    // ------------------------------------------------------------
    // Float comes only from the pin levels at the last reset edge
    a_float_entry: assert property (  // RQ1
        !$past(rst_n) |-> (mode_ff == tap_pkg::MODE_FLOAT) == $past(float_req))
        else $error("Floating mode not taken from the reset pin levels");

    a_normal_pads: assert property (  // RQ11
        mode_ff == tap_pkg::MODE_NORMAL && $past(rst_n)
            |-> pad_oe_n == $past(func_oe_n) && pulls_en)
        else $error("Normal mode pads not released");

    a_normal_strobes: assert property (  // RQ11
        mode_ff == tap_pkg::MODE_NORMAL |-> flash_output_enable_n == func_rd_strobe_n
            && flash_write_enable_n == func_wr_strobe_n)
        else $error("Flash strobe lost its normal value");

    a_xor_pulls_on: assert property (  // RQ2
        is_xor(mode_ff) |-> pulls_en)
        else $error("Pulls off in XOR mode");

    a_chain2_follows: assert property (  // RQ5 RQ10
        is_xor(mode_ff) && $changed(chain2_in) && $stable(mode_ff)
            && $countones(chain2_in ^ $past(chain2_in)) == 1
            |-> flash_write_enable_n != $past(flash_write_enable_n))
        else $error("Single toggle did not flip chain two");

    // Losing any entry level, isolation included, must end the chain mode
    a_xor_exit: assert property (  // RQ3
        is_xor(mode_ff) && !xor_req |=> mode_ff == tap_pkg::MODE_NORMAL)
        else $error("XOR mode held without its pin levels");

endmodule

// ---- include/tap_pkg.sv ----
package tap_pkg;

    // Test pin group sampled from the board tester
    typedef struct packed {
        logic select;        // Test select
        logic execute;       // test_execute_select
        logic clock;         // Test clock
        logic data_in;       // test_port_data_in
        logic isolation_n;   // bus_isolation_n
    } test_pins_t;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_FLOAT,
        MODE_XOR
    } mode_t;

    localparam int CHAIN1_LEN   = 42;
    localparam int CHAIN2_LEN   = 41;
    localparam int PAD_OUTS     = 64;

    // Pin levels that request each mode
    localparam logic FLOAT_EXECUTE = 1'b0;
    localparam logic XOR_EXECUTE   = 1'b1;
    localparam logic REQ_CLOCK     = 1'b0;
    localparam logic REQ_DATA_IN   = 1'b1;
    localparam logic REQ_SELECT    = 1'b1;

    localparam logic OE_N_DRIVE    = 1'b0;
    localparam logic OE_N_FLOAT    = 1'b1;

endpackage

// ---- tb/board_tester.sv ----
`timescale 1ns/10ps
// ----------
// Tester pins
// ----------
module board_tester (
    output tap_pkg::test_pins_t pins, // Test pin levels
    output logic [41:0]         c1,   // Chain one pads
    output logic [40:0]         c2    // Chain two pads
);
    initial
    begin
        pins = '0;
        c1 = '0;
        c2 = '0;
    end
    task automatic set_mode(input logic sel, input logic exe, input logic iso);
        pins = '{sel, exe, tap_pkg::REQ_CLOCK, tap_pkg::REQ_DATA_IN, iso};
    endtask
    // Every pad is driven, none strapped
    task automatic pads(input logic [41:0] v1, input logic [40:0] v2);
        c1 = v1;
        c2 = v2;
    endtask
endmodule

// ---- tb/xor_tree_board_test_port_test.sv ----
`timescale 1ns/10ps
module xor_tree_board_test_port_test;
    logic                mclk;
    logic                rst_n = 1'b0;
    logic                fo_n = 1'b1;
    logic                fw_n = 1'b0;
    logic [63:0]         oe_n = '0;
    logic [63:0]         pad_oe;
    logic [63:0]         r1;
    logic [63:0]         r2;
    logic                o_v, o_e, w_v, w_e, pulls;
    tap_pkg::test_pins_t pins;
    tap_pkg::mode_t      mode;
    logic [41:0]         c1;
    logic [40:0]         c2;
    int                  error_cnt = 0;
    int                  compares = 0;
    int                  seed = 32'h7f3a;

    board_tester tester_u (.pins(pins), .c1(c1), .c2(c2));
    xor_tree_board_test_port dut_u (.mclk(mclk), .rst_n(rst_n), .test_pins(pins),
        .chain1_in(c1), .chain2_in(c2), .func_rd_strobe_n(fo_n), .func_wr_strobe_n(fw_n),
        .func_oe_n(oe_n), .flash_output_enable_n(o_v), .flash_output_enable_oe_n(o_e),
        .flash_write_enable_n(w_v), .flash_write_enable_oe_n(w_e), .pad_oe_n(pad_oe),
        .pulls_en(pulls), .mode(mode));

    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (error_cnt == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    function automatic logic parity(input logic [63:0] v);
        return ^v;
    endfunction
    // Strobe enables only judged in test modes
    task automatic state(input tap_pkg::mode_t m, input logic [63:0] pd, input logic pl);
        check("mode", mode, m);
        check("pad_oe_n", pad_oe, pd);
        check("pulls_en", pulls, pl);
        if (m == tap_pkg::MODE_FLOAT)
            check("strobe oe", {o_e, w_e}, {2{tap_pkg::OE_N_FLOAT}});
        if (m == tap_pkg::MODE_XOR)
            check("strobe oe", {o_e, w_e}, {2{tap_pkg::OE_N_DRIVE}});
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial
    begin
        #400000;
        error_cnt++;
        stop_test();
    end
    initial
    begin
        // Let the tester's own start-up levels settle before the request
        #2;
        tester_u.set_mode(1'b1, 1'b0, 1'b1);
        step(8);
        rst_n = 1'b1;
        step(1);
        state(tap_pkg::MODE_FLOAT, '1, 1'b0);
        tester_u.set_mode(1'b1, 1'b1, 1'b1);
        step(2);
        state(tap_pkg::MODE_FLOAT, '1, 1'b0);
        oe_n = {$random(seed), $random(seed)};
        tester_u.set_mode(1'b0, 1'b1, 1'b1);
        step(1);
        state(tap_pkg::MODE_NORMAL, oe_n, 1'b1);
        check("output enable", o_v, fo_n);
        check("write enable", w_v, fw_n);
        tester_u.set_mode(1'b1, 1'b1, 1'b1);
        step(1);
        state(tap_pkg::MODE_XOR, '1, 1'b1);
        // Single-bit walks reach every chain position
        for (int i = 0; i < 42; i++)
        begin
            r1 = {$random(seed), $random(seed)};
            r2 = {$random(seed), $random(seed)};
            tester_u.pads(r1[41:0], r2[40:0]);
            #3;
            check("chain1", o_v, parity({22'h0, c1}));
            check("chain2", w_v, parity({23'h0, c2}));
            tester_u.pads(c1 ^ (42'h1 << i), c2 ^ (41'h1 << (i % 41)));
            #1;
            check("chain1 walk", o_v, 1'(~parity({22'h0, r1[41:0]})));
            check("chain2 walk", w_v, 1'(~parity({23'h0, r2[40:0]})));
        end
        // Single toggle across a clock edge so the clocked follow checks see it
        step(1);
        tester_u.pads(c1 ^ 42'h2, c2 ^ 41'h4);
        step(1);
        check("chain1 held", o_v, parity({22'h0, c1}));
        check("chain2 held", w_v, parity({23'h0, c2}));
        {fo_n, fw_n} = 2'($random(seed));
        tester_u.set_mode(1'b1, 1'b1, 1'b0);
        step(1);
        check("mode", mode, tap_pkg::MODE_NORMAL);
        check("output enable", o_v, fo_n);
        check("write enable", w_v, fw_n);
        rst_n = 1'b0;
        tester_u.set_mode(1'b0, 1'b0, 1'b1);
        step(2);
        state(tap_pkg::MODE_NORMAL, '1, 1'b0);
        rst_n = 1'b1;
        step(1);
        check("mode", mode, tap_pkg::MODE_NORMAL);
        state(tap_pkg::MODE_NORMAL, oe_n, 1'b1);
        stop_test();
    end
endmodule
